/* sim/irq_core_model.sv */
// Behavioural core sequencer facing the interrupt controller.
// Assumes the bench asks for returns; entry stalls the core for two cycles.
`default_nettype none
module irq_core_model #(
   parameter logic [15:0] START_PC = 16'h1234
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_vector_load,
   input wire logic [15:0] i_vector,
   input wire logic i_return_load,
   input wire logic [15:0] i_return_addr,
   input wire logic i_ret_req,
   output logic o_core_ready,
   output logic [15:0] o_pc,
   output logic o_ret_instr
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] busy_q;
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_pc <= START_PC;
      end else if (i_vector_load) begin
         o_pc <= i_vector;
      end else if (i_return_load) begin
         o_pc <= i_return_addr;
      end
   end
   // Slow entry: not at an instruction boundary right after vectoring
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         busy_q <= 2'h0;
      end else if (i_vector_load) begin
         busy_q <= 2'h2;
      end else if (busy_q != 2'h0) begin
         busy_q <= busy_q - 2'h1;
      end
   end
   assign o_core_ready = (busy_q == 2'h0);
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_ret_instr <= 1'b0;
      end else begin
         o_ret_instr <= i_ret_req && !o_ret_instr;
      end
   end
endmodule
`default_nettype wire

/* sim/tb_top.sv */
// Self-checking bench for the vectored interrupt controller.
// Assumes word-indexed registers and the core model on the vector side.
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic I_CLK = 1'b0;
   logic I_RST = 1'b1;
   logic [7:0] adr = 8'h00;
   logic rd = 1'b0, wr = 1'b0, waitreq, vload, rload, wake, core_ready, ret_instr;
   logic [31:0] wdat = 32'h0000_0000;
   logic [31:0] rdat;
   logic ext_pin = 1'b0, tck_pin = 1'b0, cap1 = 1'b0, cap2 = 1'b0, sel3 = 1'b0;
   logic t0_tick = 1'b0, t1_tick = 1'b0, t2_tick = 1'b0, t3_tick = 1'b0;
   logic tx = 1'b1, rx = 1'b0, sleeping = 1'b0, ret_req = 1'b0, wide = 1'b0;
   logic [7:0] port = 8'h00, tv8 = 8'h00;
   logic [15:0] t0 = 16'h0000, t3 = 16'h0000;
   logic [15:0] vec, raddr, pc, last_vec;
   logic [15:0] vtab [4] = '{16'h0008, 16'h0010, 16'h0018, 16'h0020};
   int failures = 0, check_count = 0, n_vec = 0, n_ret = 0;
   always #4 I_CLK = ~I_CLK;
   vectored_interrupt_control vectored_interrupt_control_inst (
      .I_CLK(I_CLK), .I_RST(I_RST), .I_AVS_ADDRESS(adr), .I_AVS_READ(rd), .I_AVS_WRITE(wr),
      .I_AVS_WRITEDATA(wdat), .I_AVS_BYTEENABLE(4'hF), .O_AVS_READDATA(rdat),
      .O_AVS_WAITREQUEST(waitreq), .I_EXT_EDGE_PIN(ext_pin), .I_TIMER_CLOCK_PIN(tck_pin),
      .I_CAPTURE1_PIN(cap1), .I_CAPTURE2_PIN(cap2), .I_CHANGE_DETECT_PORT(port),
      .I_TIMER0_TICK(t0_tick), .I_TIMER0(t0), .I_TIMER1_TICK(t1_tick), .I_TIMER1(tv8),
      .I_TIMER1_PERIOD(8'h05), .I_TIMER2_TICK(t2_tick), .I_TIMER2(tv8),
      .I_TIMER2_PERIOD(8'h05), .I_TIMER3_TICK(t3_tick), .I_TIMER3(t3),
      .I_TIMER3_PERIOD(16'h0000), .I_TIMER1_WIDE_MODE(wide),
      .I_CAPTURE1_OR_PERIOD3_SELECT(sel3), .I_SERIAL_TX_EMPTY(tx), .I_SERIAL_RX_FULL(rx),
      .I_CORE_READY(core_ready), .I_RETURN_ADDR(pc), .I_RETURN_AND_ENABLE_INSTR(ret_instr),
      .I_SLEEPING(sleeping), .O_VECTOR_LOAD(vload), .O_VECTOR(vec), .O_RETURN_LOAD(rload),
      .O_RETURN_ADDR(raddr), .O_WAKE(wake));
   irq_core_model irq_core_model_inst (
      .i_clk(I_CLK), .i_rst(I_RST), .i_vector_load(vload), .i_vector(vec),
      .i_return_load(rload), .i_return_addr(raddr), .i_ret_req(ret_req),
      .o_core_ready(core_ready), .o_pc(pc), .o_ret_instr(ret_instr));
   always @(posedge I_CLK) begin
      if (vload === 1'b1) begin
         last_vec <= vec;
         n_vec <= n_vec + 1;
      end
      if (rload === 1'b1) begin
         n_ret <= n_ret + 1;
      end
   end
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge I_CLK);
   endtask
   // Request held until waitrequest is sampled low, then released
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q);
      int n;
      n = 0;
      adr <= a;
      wr <= w;
      rd <= !w;
      wdat <= {24'h00_0000, d};
      do begin
         @(posedge I_CLK);
         n++;
      end while (waitreq !== 1'b0 && n < 50);
      if (waitreq !== 1'b0) begin
         failures++;
         summarize();
      end
      q = rdat[7:0];
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge I_CLK);
   endtask
   task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] q;
      bus(1'b0, a, 8'h00, q);
      check({8'h00, q}, {8'h00, exp});
   endtask
   task automatic wait_cnt(input int k, input logic r);
      int n;
      n = 0;
      while ((r ? n_ret : n_vec) < k && n < 60) begin
         @(posedge I_CLK);
         n++;
      end
      if ((r ? n_ret : n_vec) < k) begin
         failures++;
         summarize();
      end
   endtask
   task automatic do_ret(input int k);
      ret_req <= 1'b1;
      @(posedge I_CLK);
      ret_req <= 1'b0;
      wait_cnt(k, 1'b1);
   endtask
   initial begin
      step(4);
      I_RST <= 1'b0;
      @(posedge I_CLK);
      rd_chk(8'h06, 8'h10);
      rd_chk(8'h16, 8'h02);
      rd_chk(8'h40, 8'h00);
      $display("reset values done");
      bus_wr(8'h07, 8'h01);
      sleeping <= 1'b1;
      ext_pin <= 1'b1;
      step(6);
      ext_pin <= 1'b0;
      step(6);
      check({15'h0000, wake}, 16'h0001);
      rd_chk(8'h07, 8'h11);
      sleeping <= 1'b0;
      bus_wr(8'h06, 8'h00);
      wait_cnt(1, 1'b0);
      check(last_vec, 16'h0008);
      rd_chk(8'h06, 8'h10);
      rd_chk(8'h07, 8'h01);
      rd_chk(8'h20, 8'h08);
      rd_chk(8'h21, 8'h34);
      rd_chk(8'h22, 8'h01);
      do_ret(1);
      check(raddr, 16'h1234);
      rd_chk(8'h06, 8'h00);
      rd_chk(8'h22, 8'h00);
      $display("single vector done");
      bus_wr(8'h06, 8'h10);
      rd_chk(8'h06, 8'h10);
      bus_wr(8'h17, 8'h02);
      bus_wr(8'h07, 8'h0F);
      ext_pin <= 1'b1;
      tck_pin <= 1'b1;
      step(4);
      ext_pin <= 1'b0;
      tck_pin <= 1'b0;
      t0 <= 16'hFFFF;
      t0_tick <= 1'b1;
      step(1);
      t0_tick <= 1'b0;
      step(6);
      rd_chk(8'h07, 8'hFF);
      bus_wr(8'h06, 8'h00);
      for (int i = 0; i < 4; i++) begin
         wait_cnt(2 + i, 1'b0);
         check(last_vec, vtab[i]);
         if (i == 2) bus_wr(8'h07, 8'h0F);
         if (i == 3) bus_wr(8'h07, 8'h07);
         do_ret(2 + i);
      end
      step(10);
      check(n_vec[15:0], 16'h0005);
      rd_chk(8'h07, 8'h87);
      $display("priority order done");
      port <= 8'h01;
      rx <= 1'b1;
      cap1 <= 1'b1;
      cap2 <= 1'b1;
      sel3 <= 1'b1;
      t3 <= 16'hFFFF;
      tv8 <= 8'h05;
      step(2);
      {t1_tick, t2_tick, t3_tick, cap1, cap2} <= 5'b11100;
      step(1);
      {t1_tick, t2_tick, t3_tick} <= 3'b000;
      step(6);
      rd_chk(8'h16, 8'hFF);
      bus_wr(8'h16, 8'h00);
      rx <= 1'b0;
      step(4);
      rd_chk(8'h16, 8'h02);
      $display("peripheral flags done");
      // Rising-edge polarity on both pins; wide mode ignores the timer1 tick alone
      bus_wr(8'h06, 8'h10);
      bus_wr(8'h05, 8'hC0);
      ext_pin <= 1'b1;
      tck_pin <= 1'b1;
      wide <= 1'b1;
      t1_tick <= 1'b1;
      step(1);
      t1_tick <= 1'b0;
      step(6);
      rd_chk(8'h07, 8'hD7);
      check({15'h0000, wake}, 16'h0000);
      rd_chk(8'h16, 8'h02);
      t2_tick <= 1'b1;
      step(1);
      t2_tick <= 1'b0;
      step(4);
      rd_chk(8'h16, 8'h32);
      $display("polarity and wide mode done");
      summarize();
   end
endmodule
`default_nettype wire

/* sim/vectored_interrupt_control_sva.sv */
// Port-level assertions for the vectored interrupt controller.
// Assumes one clock domain with a synchronous active-high reset.
`default_nettype none
module irq_ctrl_sva #(
   parameter int STACK_DEPTH = 16
) (
   input wire logic I_CLK,
   input wire logic I_RST,
   input wire logic I_AVS_READ,
   input wire logic I_AVS_WRITE,
   input wire logic O_AVS_WAITREQUEST,
   input wire logic I_CORE_READY,
   input wire logic I_RETURN_AND_ENABLE_INSTR,
   input wire logic O_VECTOR_LOAD,
   input wire logic [15:0] O_VECTOR,
   input wire logic O_RETURN_LOAD
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge I_CLK);
   endclocking
   default disable iff (I_RST);
   // Only a bus write or a return can ever clear the global disable
   logic unlock_q;
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         unlock_q <= 1'b0;
      end else if (I_AVS_WRITE || I_RETURN_AND_ENABLE_INSTR) begin
         unlock_q <= 1'b1;
      end
   end
   gd_reset_a: assert property (!unlock_q |-> !O_VECTOR_LOAD)
      else $error("vector load while still disabled from reset");
   vec_legal_a: assert property (O_VECTOR_LOAD |-> O_VECTOR inside
      {16'h0008, 16'h0010, 16'h0018, 16'h0020}) else $error("illegal vector");
   accept_once_a: assert property (O_VECTOR_LOAD |=> !O_VECTOR_LOAD)
      else $error("second accept while disabled");
   accept_cond_a: assert property (O_VECTOR_LOAD |-> $past(I_CORE_READY)
      && !$past(I_RETURN_AND_ENABLE_INSTR)) else $error("accept without core boundary");
   ret_load_a: assert property (I_RETURN_AND_ENABLE_INSTR |=> O_RETURN_LOAD)
      else $error("return not popped");
   ret_cause_a: assert property (O_RETURN_LOAD |-> $past(I_RETURN_AND_ENABLE_INSTR))
      else $error("pop without return");
   ret_wins_a: assert property (I_RETURN_AND_ENABLE_INSTR |=> !O_VECTOR_LOAD)
      else $error("accept beside return");
   wait_single_a: assert property (!O_AVS_WAITREQUEST |=> O_AVS_WAITREQUEST)
      else $error("waitrequest low two cycles");
   wait_cause_a: assert property (!O_AVS_WAITREQUEST |-> $past(I_AVS_READ) || $past(I_AVS_WRITE))
      else $error("answer without request");
endmodule
bind vectored_interrupt_control irq_ctrl_sva #(.STACK_DEPTH(STACK_DEPTH)) irq_ctrl_sva_inst (
   .I_CLK(I_CLK), .I_RST(I_RST), .I_AVS_READ(I_AVS_READ), .I_AVS_WRITE(I_AVS_WRITE),
   .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST), .I_CORE_READY(I_CORE_READY),
   .I_RETURN_AND_ENABLE_INSTR(I_RETURN_AND_ENABLE_INSTR), .O_VECTOR_LOAD(O_VECTOR_LOAD),
   .O_VECTOR(O_VECTOR), .O_RETURN_LOAD(O_RETURN_LOAD));
`default_nettype wire

/* verilog/irq_ctrl_pkg.sv */
// Constants and register map for the vectored interrupt controller.
// Assumes a 125 MHz core clock and an Avalon-MM word-addressed register bus.
// How it works
// R1 - Summary flag is OR of peripheral requests ANDed with their enables.
// R2 - Global disable bit 4 blocks every interrupt when set.
// R3 - Reset sets the global disable bit.
// R4 - Acceptance sets global disable, pushes return address, loads the vector.
// R5 - Simultaneous pending interrupts served by fixed priority, 1 highest.
// R6 - Vectors 0008h, 0010h, 0018h, 0020h for the four sources.
// R7 - Request flags set by events regardless of enables or global disable.
// R8 - Return-and-enable pops return address and clears global disable together.
// R9 - Peripheral request needs both group enable and its own enable.
// R10 - External pin edge chosen by timer0 status bit 7, sets flag bit 4.
// R11 - External pin enable at bit 0; enabled pin interrupt wakes from sleep.
// R12 - Timer0 rollover sets flag bit 5; enable bit 1 gates it.
// R13 - Timer clock pin edge by status bit 6 sets flag bit 6; enable bit 2.
// R14 - Vectoring to external or timer0 vector clears that flag.
// R15 - Software polls and clears serviced peripheral flags before re-enabling.
// R16 - Port change request bit 7 set on port change; software ends mismatch.
// R17 - Timer3 request bit 6: overflow with capture1, else period rollover.
// R18 - Timer2 request bit 5 set on rollover after period match.
// R19 - Timer1 request bit 4: 8-bit or 16-bit paired period rollover.
// R20 - Capture events set capture2 bit 3 and capture1 bit 2.
// R21 - Serial tx bit 1 reads buffer empty, rx bit 0 buffer full.
// R22 - Software sets global disable before clearing individual enables.
// R23 - Early variant software re-checks global disable after setting it.
`default_nettype none
package irq_ctrl_pkg;
   localparam int ADDR_W = 8;
   localparam logic [7:0] ADDR_CORE_STATUS = 8'h07;
   localparam logic [7:0] ADDR_PROC_STATUS = 8'h06;
   localparam logic [7:0] ADDR_TIMER0_STATUS = 8'h05;
   localparam logic [7:0] ADDR_PERIPH_FLAGS = 8'h16;
   localparam logic [7:0] ADDR_PERIPH_ENABLE = 8'h17;
   localparam logic [7:0] ADDR_VECTOR = 8'h20;
   localparam logic [7:0] ADDR_STACK_TOP = 8'h21;
   localparam logic [7:0] ADDR_STACK_DEPTH = 8'h22;
   localparam int GLOBAL_DIS_BIT = 4;
   localparam int EXT_POL_BIT = 7;
   localparam int TCK_POL_BIT = 6;
   localparam int EXT_EN_BIT = 0;
   localparam int T0_EN_BIT = 1;
   localparam int TCK_EN_BIT = 2;
   localparam int GRP_EN_BIT = 3;
   localparam int EXT_FLAG_BIT = 4;
   localparam int T0_FLAG_BIT = 5;
   localparam int TCK_FLAG_BIT = 6;
   localparam int SUM_FLAG_BIT = 7;
   localparam int P_PORT = 7;
   localparam int P_T3 = 6;
   localparam int P_T2 = 5;
   localparam int P_T1 = 4;
   localparam int P_CAP2 = 3;
   localparam int P_CAP1 = 2;
   localparam int P_TX = 1;
   localparam int P_RX = 0;
   localparam logic [7:0] PERIPH_SW_MASK = 8'hFC;
   localparam logic [7:0] CORE_SW_MASK = 8'h7F;
   localparam logic [15:0] VEC_EXT = 16'h0008;
   localparam logic [15:0] VEC_T0 = 16'h0010;
   localparam logic [15:0] VEC_TCK = 16'h0018;
   localparam logic [15:0] VEC_PERIPH = 16'h0020;
   localparam logic [15:0] ROLL_MAX = 16'hFFFF;
   localparam logic [7:0] PROC_RESET = 8'h10;
   localparam logic [7:0] ZERO8 = 8'h00;
   localparam logic [31:0] ZERO32 = 32'h0000_0000;
endpackage
`default_nettype wire

/* verilog/irq_return_stack.sv */
// Hardware return-address stack for interrupt entry and return.
// Assumes push and pop are never requested in the same cycle.
`default_nettype none
module irq_return_stack #(
   parameter int DEPTH = 16
) (
   input wire logic i_clk,
   input wire logic i_rst,
   irq_stack_if.store s
);
   logic [15:0] mem_q [DEPTH];
   logic [4:0] ptr_q;
   logic [15:0] top_q;

   always_ff @(posedge i_clk) begin
      if (s.push) begin
         mem_q[ptr_q[3:0]] <= s.push_data;
      end
   end

   // Pointer saturates at DEPTH; an overflow push writes slot ptr_q[3:0], the oldest entry when DEPTH is 16
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         ptr_q <= 5'h00;
         top_q <= 16'h0000;
      end else if (s.push) begin
         ptr_q <= (ptr_q == 5'(DEPTH)) ? ptr_q : ptr_q + 5'h01;
         top_q <= s.push_data;
      end else if (s.pop) begin
         ptr_q <= (ptr_q == 5'h00) ? ptr_q : ptr_q - 5'h01;
         top_q <= (ptr_q > 5'h01) ? mem_q[4'(ptr_q - 5'h02)] : 16'h0000;
      end
   end

   assign s.top = top_q;
   assign s.depth = ptr_q;
endmodule
`default_nettype wire

/* verilog/irq_stack_if.sv */
// Push and pop handshake between the controller and its return stack.
// Assumes both ends share the core clock.
`default_nettype none
interface irq_stack_if;
   logic push;
   logic pop;
   logic [15:0] push_data;
   logic [15:0] top;
   logic [4:0] depth;
   modport ctrl (output push, output pop, output push_data, input top, input depth);
   modport store (input push, input pop, input push_data, output top, output depth);
endinterface
`default_nettype wire

/* verilog/vectored_interrupt_control.sv */
// Interrupt gathering, masking, priority and vectoring for the core.
// Assumes core events arrive as same-clock pulses; pins pass synchronisers.
`default_nettype none
module vectored_interrupt_control #(
   parameter int STACK_DEPTH = 16
) (
   input wire logic I_CLK,
   input wire logic I_RST,
   input wire logic [7:0] I_AVS_ADDRESS,
   input wire logic I_AVS_READ,
   input wire logic I_AVS_WRITE,
   input wire logic [31:0] I_AVS_WRITEDATA,
   input wire logic [3:0] I_AVS_BYTEENABLE,
   output logic [31:0] O_AVS_READDATA,
   output logic O_AVS_WAITREQUEST,
   input wire logic I_EXT_EDGE_PIN,
   input wire logic I_TIMER_CLOCK_PIN,
   input wire logic I_CAPTURE1_PIN,
   input wire logic I_CAPTURE2_PIN,
   input wire logic [7:0] I_CHANGE_DETECT_PORT,
   input wire logic I_TIMER0_TICK,
   input wire logic [15:0] I_TIMER0,
   input wire logic I_TIMER1_TICK,
   input wire logic [7:0] I_TIMER1,
   input wire logic [7:0] I_TIMER1_PERIOD,
   input wire logic I_TIMER2_TICK,
   input wire logic [7:0] I_TIMER2,
   input wire logic [7:0] I_TIMER2_PERIOD,
   input wire logic I_TIMER3_TICK,
   input wire logic [15:0] I_TIMER3,
   input wire logic [15:0] I_TIMER3_PERIOD,
   input wire logic I_TIMER1_WIDE_MODE,
   input wire logic I_CAPTURE1_OR_PERIOD3_SELECT,
   input wire logic I_SERIAL_TX_EMPTY,
   input wire logic I_SERIAL_RX_FULL,
   input wire logic I_CORE_READY,
   input wire logic [15:0] I_RETURN_ADDR,
   input wire logic I_RETURN_AND_ENABLE_INSTR,
   input wire logic I_SLEEPING,
   output logic O_VECTOR_LOAD,
   output logic [15:0] O_VECTOR,
   output logic O_RETURN_LOAD,
   output logic [15:0] O_RETURN_ADDR,
   output logic O_WAKE
);
   typedef enum logic [1:0] {SRC_EXT, SRC_T0, SRC_TCK, SRC_PERIPH} src_t;
   typedef enum {IDLE, ANSWER} bus_t;

   irq_stack_if stk ();
   irq_return_stack #(.DEPTH(STACK_DEPTH)) u_stack (
      .i_clk(I_CLK),
      .i_rst(I_RST),
      .s(stk)
   );

   // Two-flop synchronisers; a third stage keeps edge detection off the first flop
   logic [3:0] pin_s1_q, pin_s2_q, pin_s3_q;
   logic [7:0] port_s1_q, port_s2_q, port_ref_q;
   always_ff @(posedge I_CLK) begin
      pin_s1_q <= {I_CAPTURE2_PIN, I_CAPTURE1_PIN, I_TIMER_CLOCK_PIN, I_EXT_EDGE_PIN};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      port_s1_q <= I_CHANGE_DETECT_PORT;
      port_s2_q <= port_s1_q;
   end

   logic [7:0] proc_status_q, timer0_status_q, core_irq_status_enable_q;
   logic [7:0] peripheral_request_flags_q, peripheral_enable_mask_q;
   logic ext_edge, tck_edge, cap1_edge, cap2_edge;
   logic t0_roll, t1_roll, t2_roll, t3_roll;
   logic port_mismatch;

   // Rising edge if polarity bit set, falling if clear [R10] [R13]
   assign ext_edge = timer0_status_q[irq_ctrl_pkg::EXT_POL_BIT] ?
                     (pin_s2_q[0] & ~pin_s3_q[0]) : (~pin_s2_q[0] & pin_s3_q[0]);
   assign tck_edge = timer0_status_q[irq_ctrl_pkg::TCK_POL_BIT] ?
                     (pin_s2_q[1] & ~pin_s3_q[1]) : (~pin_s2_q[1] & pin_s3_q[1]);
   // Capture on falling edge, the usual capture default
   assign cap1_edge = ~pin_s2_q[2] & pin_s3_q[2]; // [R20]
   assign cap2_edge = ~pin_s2_q[3] & pin_s3_q[3]; // [R20]
   assign t0_roll = I_TIMER0_TICK & (I_TIMER0 == irq_ctrl_pkg::ROLL_MAX); // [R12]
   // Rollovers: timer counted from period, or timer3 from ROLL_MAX when selected, back to zero [R17] [R18] [R19]
   assign t2_roll = I_TIMER2_TICK & (I_TIMER2 == I_TIMER2_PERIOD);
   assign t1_roll = I_TIMER1_WIDE_MODE ?
                    (I_TIMER2_TICK & ({I_TIMER1, I_TIMER2} ==
                                      {I_TIMER1_PERIOD, I_TIMER2_PERIOD})) :
                    (I_TIMER1_TICK & (I_TIMER1 == I_TIMER1_PERIOD));
   assign t3_roll = I_TIMER3_TICK & (I_CAPTURE1_OR_PERIOD3_SELECT ?
                    (I_TIMER3 == irq_ctrl_pkg::ROLL_MAX) : (I_TIMER3 == I_TIMER3_PERIOD));
   assign port_mismatch = port_s2_q != port_ref_q;

   logic sum_flag;
   assign sum_flag = |(peripheral_request_flags_q & peripheral_enable_mask_q); // [R1]

   // Gated requests
   logic ext_req, t0_req, tck_req, per_req, any_req, glob_dis;
   assign glob_dis = proc_status_q[irq_ctrl_pkg::GLOBAL_DIS_BIT];
   assign ext_req = core_irq_status_enable_q[irq_ctrl_pkg::EXT_FLAG_BIT] &
                    core_irq_status_enable_q[irq_ctrl_pkg::EXT_EN_BIT]; // [R11]
   assign t0_req = core_irq_status_enable_q[irq_ctrl_pkg::T0_FLAG_BIT] &
                   core_irq_status_enable_q[irq_ctrl_pkg::T0_EN_BIT]; // [R12]
   assign tck_req = core_irq_status_enable_q[irq_ctrl_pkg::TCK_FLAG_BIT] &
                    core_irq_status_enable_q[irq_ctrl_pkg::TCK_EN_BIT]; // [R13]
   assign per_req = sum_flag & core_irq_status_enable_q[irq_ctrl_pkg::GRP_EN_BIT]; // [R9]
   assign any_req = ext_req | t0_req | tck_req | per_req;

   // Accept only when the core is at an instruction boundary and not returning
   logic accept;
   assign accept = any_req & ~glob_dis & I_CORE_READY & ~I_RETURN_AND_ENABLE_INSTR; // [R2]

   src_t win;
   always_comb begin
      if (ext_req) begin // [R5]
         win = SRC_EXT;
      end else if (t0_req) begin
         win = SRC_T0;
      end else if (tck_req) begin
         win = SRC_TCK;
      end else begin
         win = SRC_PERIPH;
      end
   end

   logic [15:0] win_vec;
   always_comb begin
      unique case (win)
         SRC_EXT: win_vec = irq_ctrl_pkg::VEC_EXT; // [R6]
         SRC_T0: win_vec = irq_ctrl_pkg::VEC_T0;
         SRC_TCK: win_vec = irq_ctrl_pkg::VEC_TCK;
         SRC_PERIPH: win_vec = irq_ctrl_pkg::VEC_PERIPH;
      endcase
   end

   // Bus decode: one wait cycle then answer
   bus_t bus_q;
   logic wr_hit, rd_hit;
   assign wr_hit = (bus_q == ANSWER) & I_AVS_WRITE & I_AVS_BYTEENABLE[0];
   assign rd_hit = (bus_q == ANSWER) & I_AVS_READ;

   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         bus_q <= IDLE;
         O_AVS_WAITREQUEST <= 1'b1;
      end else begin
         unique case (bus_q)
            IDLE: begin
               if (I_AVS_READ | I_AVS_WRITE) begin
                  bus_q <= ANSWER;
                  O_AVS_WAITREQUEST <= 1'b0;
               end
            end
            ANSWER: begin
               bus_q <= IDLE;
               O_AVS_WAITREQUEST <= 1'b1;
            end
         endcase
      end
   end

   logic [7:0] rd_byte;
   always_comb begin
      unique case (I_AVS_ADDRESS)
         irq_ctrl_pkg::ADDR_CORE_STATUS:
            rd_byte = {sum_flag, core_irq_status_enable_q[6:0]}; // [R1]
         irq_ctrl_pkg::ADDR_PROC_STATUS: rd_byte = proc_status_q;
         irq_ctrl_pkg::ADDR_TIMER0_STATUS: rd_byte = timer0_status_q;
         irq_ctrl_pkg::ADDR_PERIPH_FLAGS: rd_byte = peripheral_request_flags_q;
         irq_ctrl_pkg::ADDR_PERIPH_ENABLE: rd_byte = peripheral_enable_mask_q;
         irq_ctrl_pkg::ADDR_VECTOR: rd_byte = O_VECTOR[7:0];
         irq_ctrl_pkg::ADDR_STACK_TOP: rd_byte = stk.top[7:0];
         irq_ctrl_pkg::ADDR_STACK_DEPTH: rd_byte = {3'b000, stk.depth};
         default: rd_byte = irq_ctrl_pkg::ZERO8;
      endcase
   end

   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         O_AVS_READDATA <= irq_ctrl_pkg::ZERO32;
      end else if ((bus_q == IDLE) & I_AVS_READ) begin
         O_AVS_READDATA <= {24'h00_0000, rd_byte};
      end
   end

   // Global disable: set at reset and on acceptance, cleared on return [R3] [R4] [R8]
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         proc_status_q <= irq_ctrl_pkg::PROC_RESET; // [R3]
      end else if (accept) begin
         proc_status_q[irq_ctrl_pkg::GLOBAL_DIS_BIT] <= 1'b1; // [R4]
      end else if (I_RETURN_AND_ENABLE_INSTR) begin
         proc_status_q[irq_ctrl_pkg::GLOBAL_DIS_BIT] <= 1'b0; // [R8]
      end else if (wr_hit & (I_AVS_ADDRESS == irq_ctrl_pkg::ADDR_PROC_STATUS)) begin
         proc_status_q <= I_AVS_WRITEDATA[7:0];
      end
   end

   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         timer0_status_q <= irq_ctrl_pkg::ZERO8;
      end else if (wr_hit & (I_AVS_ADDRESS == irq_ctrl_pkg::ADDR_TIMER0_STATUS)) begin
         timer0_status_q <= I_AVS_WRITEDATA[7:0];
      end
   end

   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         peripheral_enable_mask_q <= irq_ctrl_pkg::ZERO8;
      end else if (wr_hit & (I_AVS_ADDRESS == irq_ctrl_pkg::ADDR_PERIPH_ENABLE)) begin
         peripheral_enable_mask_q <= I_AVS_WRITEDATA[7:0];
      end
   end

   // Core flags: software write, event sets win, vector clears [R7] [R14]
   logic [7:0] core_d;
   always_comb begin
      core_d = core_irq_status_enable_q;
      if (wr_hit & (I_AVS_ADDRESS == irq_ctrl_pkg::ADDR_CORE_STATUS)) begin
         core_d = (core_d & ~irq_ctrl_pkg::CORE_SW_MASK) |
                  (I_AVS_WRITEDATA[7:0] & irq_ctrl_pkg::CORE_SW_MASK);
      end
      if (accept & (win == SRC_EXT)) begin
         core_d[irq_ctrl_pkg::EXT_FLAG_BIT] = 1'b0; // [R14]
      end
      if (accept & (win == SRC_T0)) begin
         core_d[irq_ctrl_pkg::T0_FLAG_BIT] = 1'b0; // [R14]
      end
      if (ext_edge) begin
         core_d[irq_ctrl_pkg::EXT_FLAG_BIT] = 1'b1; // [R7] [R10]
      end
      if (t0_roll) begin
         core_d[irq_ctrl_pkg::T0_FLAG_BIT] = 1'b1; // [R7] [R12]
      end
      if (tck_edge) begin
         core_d[irq_ctrl_pkg::TCK_FLAG_BIT] = 1'b1; // [R7] [R13]
      end
      core_d[irq_ctrl_pkg::SUM_FLAG_BIT] = 1'b0;
   end

   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         core_irq_status_enable_q <= irq_ctrl_pkg::ZERO8;
      end else begin
         core_irq_status_enable_q <= core_d;
      end
   end

   // Peripheral flags: set wins over software clear [R7] [R15]
   logic [7:0] per_d, per_set;
   always_comb begin
      per_set = irq_ctrl_pkg::ZERO8;
      per_set[irq_ctrl_pkg::P_PORT] = port_mismatch; // [R16]
      per_set[irq_ctrl_pkg::P_T3] = t3_roll; // [R17]
      per_set[irq_ctrl_pkg::P_T2] = t2_roll; // [R18]
      per_set[irq_ctrl_pkg::P_T1] = t1_roll; // [R19]
      per_set[irq_ctrl_pkg::P_CAP2] = cap2_edge; // [R20]
      per_set[irq_ctrl_pkg::P_CAP1] = cap1_edge; // [R20]
      per_d = peripheral_request_flags_q;
      if (wr_hit & (I_AVS_ADDRESS == irq_ctrl_pkg::ADDR_PERIPH_FLAGS)) begin
         per_d = (per_d & ~irq_ctrl_pkg::PERIPH_SW_MASK) |
                 (I_AVS_WRITEDATA[7:0] & irq_ctrl_pkg::PERIPH_SW_MASK);
      end
      per_d = per_d | per_set;
      per_d[irq_ctrl_pkg::P_TX] = I_SERIAL_TX_EMPTY; // [R21]
      per_d[irq_ctrl_pkg::P_RX] = I_SERIAL_RX_FULL; // [R21]
   end

   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         peripheral_request_flags_q <= irq_ctrl_pkg::ZERO8;
      end else begin
         peripheral_request_flags_q <= per_d;
      end
   end

   // Port mismatch lasts until software reads the peripheral flags register, refreshing the reference [R16]
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         port_ref_q <= irq_ctrl_pkg::ZERO8;
      end else if (rd_hit & (I_AVS_ADDRESS == irq_ctrl_pkg::ADDR_PERIPH_FLAGS)) begin
         port_ref_q <= port_s2_q;
      end
   end

   // Entry pushes return address, return pops it [R4] [R8]
   assign stk.push = accept;
   assign stk.push_data = I_RETURN_ADDR;
   assign stk.pop = I_RETURN_AND_ENABLE_INSTR;

   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         O_VECTOR_LOAD <= 1'b0;
         O_VECTOR <= irq_ctrl_pkg::VEC_EXT;
         O_RETURN_LOAD <= 1'b0;
         O_RETURN_ADDR <= 16'h0000;
         O_WAKE <= 1'b0;
      end else begin
         O_VECTOR_LOAD <= accept; // [R4]
         if (accept) begin
            O_VECTOR <= win_vec; // [R4] [R6]
         end
         O_RETURN_LOAD <= I_RETURN_AND_ENABLE_INSTR;
         if (I_RETURN_AND_ENABLE_INSTR) begin
            O_RETURN_ADDR <= stk.top; // [R8]
         end
         // Enabled pin interrupts wake regardless of global disable [R11] [R13]
         O_WAKE <= I_SLEEPING & (ext_req | tck_req);
      end
   end
endmodule
`default_nettype wire
